// ---- hw/lmr_pkg.sv ----
// constants shared by the line monitor readback block
// Functional notes
// - The power monitor register shows the live power of the transistor picked by the power monitor selector.
// - The selector is three bits where 000 to 101 pick Q1 to Q6 in order and 110 and 111 are undefined.
// - For Q1, Q2, Q5 and Q6 the power code runs linearly from 0 W at 0x00 to 7.8 W at 0xFF in 30.4 mW counts.
// - For Q3 and Q4 the power code runs linearly from 0 W at 0x00 to 0.9 W at full scale in 3.62 mW counts.
// - Bit 6 of the loop voltage register is 0 when TIP is above RING and 1 when TIP is below RING.
// - Bits 5:0 of the loop voltage register give the TIP minus RING magnitude from 0 V to 94.5 V in 1.5 V counts.
// - Bit 6 of the loop current register is 0 for forward current and 1 for reverse current.
// - Bits 5:0 of the loop current register give the loop current magnitude from 0 mA to 78.75 mA in 1.25 mA counts.
// - The TIP register gives the TIP to ground voltage as 0 V at 0x00 falling to -95.88 V at 0xFF in .376 V counts.
// - The RING register gives the RING to ground voltage with the same .376 V per count scaling up to 0xFF.
package lmr_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets on the control port
  localparam logic [7:0] SEL_OFS  = 8'h4C;
  localparam logic [7:0] PWR_OFS  = 8'h4D;
  localparam logic [7:0] LV_OFS   = 8'h4E;
  localparam logic [7:0] LC_OFS   = 8'h4F;
  localparam logic [7:0] TIP_OFS  = 8'h50;
  localparam logic [7:0] RING_OFS = 8'h51;

  // values after reset
  localparam logic [7:0] MON_RST  = 8'h00;
  localparam logic [2:0] SEL_RST  = 3'h0;

  // field positions
  localparam int SIGN_POS = 6;
  localparam int MAG_MSB  = 5;
  localparam int SEL_MSB  = 2;
  localparam logic [5:0] MAG_MAX = 6'h3F;
  localparam logic [7:0] CODE_MAX = 8'hFF;

  // selector codes
  localparam logic [2:0] SEL_Q1 = 3'h0;
  localparam logic [2:0] SEL_Q2 = 3'h1;
  localparam logic [2:0] SEL_Q3 = 3'h2;
  localparam logic [2:0] SEL_Q4 = 3'h3;
  localparam logic [2:0] SEL_Q5 = 3'h4;
  localparam logic [2:0] SEL_Q6 = 3'h5;
  localparam int NUM_Q = 6;

  // scaling: power comes in microwatts
  localparam int PWR_W         = 23;
  localparam int PWR_HI_LSB_UW = 30400;
  localparam int PWR_LO_LSB_UW = 3620;
  localparam int RECIP_SHIFT   = 24;
  localparam int PWR_HI_RECIP  = ((1 << RECIP_SHIFT) + PWR_HI_LSB_UW / 2)
                                 / PWR_HI_LSB_UW;
  localparam int PWR_LO_RECIP  = ((1 << RECIP_SHIFT) + PWR_LO_LSB_UW / 2)
                                 / PWR_LO_LSB_UW;

  // scaling: line voltages in millivolts, current in microamps
  localparam int TIP_LSB_MV    = 376;
  localparam int LOOP_LSB_MV   = 1500;
  localparam int LC_LSB_UA     = 1250;
  localparam int LC_RAW_LSB_UA = 250;
  localparam int MAG_SHIFT     = 10;
  localparam int LV_MULT = ((TIP_LSB_MV << MAG_SHIFT) + LOOP_LSB_MV / 2)
                           / LOOP_LSB_MV;
  localparam int LC_MULT = ((LC_RAW_LSB_UA << MAG_SHIFT) + LC_LSB_UA / 2)
                           / LC_LSB_UA;
  localparam int LC_RAW_W = 10;

  // publish period of the readback registers
  localparam int CLK_NS     = 50;
  localparam int UPDATE_NS  = 1000;
  localparam int UPDATE_CYC = (UPDATE_NS + CLK_NS - 1) / CLK_NS;

endpackage

// ---- hw/lmr_sign_mag.sv ----
// signed sample to polarity bit and saturating 6-bit magnitude
`timescale 1ns/1ns
module lmr_sign_mag
  import lmr_pkg::*;
#(
  parameter int IN_W  = 9,
  parameter int MULT  = 1,
  parameter int SHIFT = 0
)
(
  input  wire logic signed [IN_W-1:0] value_in,
  output logic                        neg,
  output logic [MAG_MSB:0]            mag
);
  localparam logic [15:0] MULT_V = 16'(MULT);
  logic [IN_W-1:0]  abs_v;
  logic [IN_W+15:0] prod;
  logic [IN_W+15:0] scaled;

  // magnitude via reciprocal multiply, clipped at full scale
  always_comb
  begin
    neg    = value_in[IN_W-1];
    abs_v  = neg ? IN_W'(-value_in) : IN_W'(value_in);
    prod   = (IN_W+16)'(abs_v) * (IN_W+16)'(MULT_V);
    scaled = prod >> SHIFT;
    if (scaled > (IN_W+16)'(MAG_MAX))
      mag = MAG_MAX;
    else
      mag = scaled[MAG_MSB:0];
  end
endmodule // lmr_sign_mag

// ---- hw/lmr_power_code.sv ----
// converts one transistor power in microwatts to the 8-bit power code
`timescale 1ns/1ns
module lmr_power_code
  import lmr_pkg::*;
(
  input  wire logic [PWR_W-1:0] power_uw,
  input  wire logic [2:0]       sel,
  output logic [7:0]            code
);
  localparam logic [15:0] HI_R = 16'(PWR_HI_RECIP);
  localparam logic [15:0] LO_R = 16'(PWR_LO_RECIP);
  logic [15:0]       recip;
  logic [PWR_W+15:0] prod;
  logic [PWR_W+15:0] scaled;

  // small transistors use the fine scale, big ones the coarse one
  always_comb
  begin
    case (sel)
      SEL_Q1, SEL_Q2, SEL_Q5, SEL_Q6: recip = HI_R;
      SEL_Q3, SEL_Q4:                 recip = LO_R;
      default:                        recip = 16'h0000;
    endcase
    prod   = (PWR_W+16)'(power_uw) * (PWR_W+16)'(recip);
    scaled = prod >> RECIP_SHIFT;
    // above full scale the code pins at 0xFF rather than wrapping
    if (scaled > (PWR_W+16)'(CODE_MAX))
      code = CODE_MAX;
    else
      code = scaled[7:0];
  end
endmodule // lmr_power_code

// ---- hw/lmr_line_monitor.sv ----
// line monitor readback registers: power, loop and line voltages
`timescale 1ns/1ns
module lmr_line_monitor
  import lmr_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYC
)
(
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  input  wire logic [ADDR_W-1:0]          ADDR,
  input  wire logic [DATA_W-1:0]          WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic [DATA_W-1:0]               RDATA,
  input  wire logic                       MEAS_VALID,
  input  wire logic [7:0]                 TIP_CODE,
  input  wire logic [7:0]                 RING_CODE,
  input  wire logic signed [LC_RAW_W-1:0] LOOP_CURRENT,
  input  wire logic [PWR_W-1:0]           Q1_POWER,
  input  wire logic [PWR_W-1:0]           Q2_POWER,
  input  wire logic [PWR_W-1:0]           Q3_POWER,
  input  wire logic [PWR_W-1:0]           Q4_POWER,
  input  wire logic [PWR_W-1:0]           Q5_POWER,
  input  wire logic [PWR_W-1:0]           Q6_POWER,
  output logic [2:0]                      SELECTOR,
  output logic                            UPDATE_TICK
);

  // publish phase of the readback path
  typedef enum logic [1:0] {
    LMR_IDLE,
    LMR_CONVERT,
    LMR_PUBLISH
  } lmr_state_t;

  // counter sized for the period itself; the +1 keeps a period of one
  // from collapsing the counter to zero bits
  localparam int CNT_W = $clog2(UPDATE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(UPDATE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // front-end hold registers, written on each valid sample
  logic [PWR_W-1:0]           q_hold [NUM_Q];
  logic [PWR_W-1:0]           q_in   [NUM_Q];
  logic [7:0]                 tip_hold;
  logic [7:0]                 ring_hold;
  logic signed [LC_RAW_W-1:0] lc_hold;
  logic                       fresh;

  // snapshot taken at the start of a publish cycle
  logic [PWR_W-1:0]           pwr_snap;
  logic [2:0]                 sel_snap;
  logic [7:0]                 tip_snap;
  logic [7:0]                 ring_snap;
  logic signed [LC_RAW_W-1:0] lc_snap;

  // software-visible registers
  logic [2:0]                 power_monitor_selector;
  logic [7:0]                 power_output_value;
  logic                       loop_voltage_sign;
  logic [MAG_MSB:0]           loop_voltage_magnitude;
  logic                       loop_current_direction;
  logic [MAG_MSB:0]           loop_current_magnitude;
  logic [7:0]                 tip_ground_voltage;
  logic [7:0]                 ring_ground_voltage;

  // converter results
  logic [7:0]                 next_power;
  logic signed [8:0]          loop_diff;
  logic                       next_lv_sign;
  logic [MAG_MSB:0]           next_lv_mag;
  logic                       next_lc_dir;
  logic [MAG_MSB:0]           next_lc_mag;

  // control
  lmr_state_t                 state;
  lmr_state_t                 next_state;
  logic [CNT_W-1:0]           div_cnt;
  logic                       tick;
  logic [DATA_W-1:0]          next_rdata;

  // gather the six power inputs so one index picks the selected one
  assign q_in[0] = Q1_POWER;
  assign q_in[1] = Q2_POWER;
  assign q_in[2] = Q3_POWER;
  assign q_in[3] = Q4_POWER;
  assign q_in[4] = Q5_POWER;
  assign q_in[5] = Q6_POWER;

  // rate divider: one enable pulse per publish period
  // the period parameter may take any value of one or more
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      div_cnt <= CNT_ZERO;
    else if (div_cnt == CNT_LAST)
      div_cnt <= CNT_ZERO;
    else
      div_cnt <= div_cnt + CNT_W'(1);
  end

  // one-cycle enable at the last count; the whole block stays on CLK
  // so no second clock domain has to be crossed
  assign tick = (div_cnt == CNT_LAST);

  // every transistor is held, so a selector change between samples
  // still finds a real measurement for the new transistor
  genvar gi;
  generate
    for (gi = 0; gi < NUM_Q; gi++)
    begin : g_qhold
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          q_hold[gi] <= '0;
        else if (MEAS_VALID)
          q_hold[gi] <= q_in[gi];
      end
    end
  endgenerate

  // line sample hold
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tip_hold  <= MON_RST;
      ring_hold <= MON_RST;
      lc_hold   <= '0;
    end
    else if (MEAS_VALID)
    begin
      tip_hold  <= TIP_CODE;
      ring_hold <= RING_CODE;
      lc_hold   <= LOOP_CURRENT;
    end
  end

  // fresh marks a sample not yet published; a new sample in the same
  // cycle as the snapshot keeps it set so that sample is not lost
  // the set wins over the clear when both fall in one cycle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      fresh <= 1'b0;
    else if (MEAS_VALID)
      fresh <= 1'b1;
    else if (state == LMR_IDLE && tick)
      fresh <= 1'b0;
  end

  // publish sequencer: snapshot, convert, then load the registers
  always_comb
  begin
    next_state = state;
    case (state)
      LMR_IDLE:
        if (tick && fresh)
          next_state = LMR_CONVERT;
      LMR_CONVERT:
        next_state = LMR_PUBLISH;
      LMR_PUBLISH:
        next_state = LMR_IDLE;
      default:
        next_state = LMR_IDLE;
    endcase
  end

  // state register; reset returns to idle with no publish pending
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      state <= LMR_IDLE;
    else
      state <= next_state;
  end

  // one coherent snapshot so tip, ring and loop voltage always agree
  // the snapshot is taken only on a tick with a fresh sample, so a
  // quiet front end leaves the registers at their last values
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pwr_snap  <= '0;
      sel_snap  <= SEL_RST;
      tip_snap  <= MON_RST;
      ring_snap <= MON_RST;
      lc_snap   <= '0;
    end
    else if (state == LMR_IDLE && tick && fresh)
    begin
      // undefined selector codes snapshot zero power
      if (power_monitor_selector < 3'(NUM_Q))
        pwr_snap <= q_hold[power_monitor_selector];
      else
        pwr_snap <= '0;
      sel_snap  <= power_monitor_selector;
      tip_snap  <= tip_hold;
      ring_snap <= ring_hold;
      lc_snap   <= lc_hold;
    end
  end

  // power scaling depends on which transistor was captured
  // the captured selector, not the live one, picks the scale, so a
  // selector write during conversion cannot mix two scales
  lmr_power_code u_power
  (
    .power_uw (pwr_snap),
    .sel      (sel_snap),
    .code     (next_power)
  );

  // tip minus ring is (ring code - tip code) counts of .376 V,
  // since both line codes count downward from ground
  assign loop_diff = $signed({1'b0, ring_snap}) - $signed({1'b0, tip_snap});

  // loop voltage: the 9-bit difference cannot overflow for 8-bit codes
  lmr_sign_mag #(
    .IN_W  (9),
    .MULT  (LV_MULT),
    .SHIFT (MAG_SHIFT)
  ) u_loop_v
  (
    .value_in   (loop_diff),
    .neg        (next_lv_sign),
    .mag        (next_lv_mag)
  );

  // loop current: reverse flow arrives as a negative sample
  lmr_sign_mag #(
    .IN_W  (LC_RAW_W),
    .MULT  (LC_MULT),
    .SHIFT (MAG_SHIFT)
  ) u_loop_i
  (
    .value_in   (lc_snap),
    .neg        (next_lc_dir),
    .mag        (next_lc_mag)
  );

  // power monitor register
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      power_output_value <= MON_RST;
    else if (state == LMR_PUBLISH)
      power_output_value <= next_power;
  end

  // loop voltage register
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      loop_voltage_sign      <= 1'b0;
      loop_voltage_magnitude <= '0;
    end
    else if (state == LMR_PUBLISH)
    begin
      loop_voltage_sign      <= next_lv_sign;
      loop_voltage_magnitude <= next_lv_mag;
    end
  end

  // loop current register
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      loop_current_direction <= 1'b0;
      loop_current_magnitude <= '0;
    end
    else if (state == LMR_PUBLISH)
    begin
      loop_current_direction <= next_lc_dir;
      loop_current_magnitude <= next_lc_mag;
    end
  end

  // line to ground registers pass the converter code straight through
  // the codes already have the register's scale and count downward
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tip_ground_voltage  <= MON_RST;
      ring_ground_voltage <= MON_RST;
    end
    else if (state == LMR_PUBLISH)
    begin
      tip_ground_voltage  <= tip_snap;
      ring_ground_voltage <= ring_snap;
    end
  end

  // selector is the only writable field; monitor offsets drop writes
  // bits 7:3 of a selector write are dropped and read back as zero
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      power_monitor_selector <= SEL_RST;
    else if (WR && ADDR == SEL_OFS)
      power_monitor_selector <= WDATA[SEL_MSB:0];
  end

  // read mux; reads have no side effect on any hold or register
  // unmapped offsets read as zero so a stray read never aliases
  always_comb
  begin
    case (ADDR)
      SEL_OFS:  next_rdata = {5'h00, power_monitor_selector};
      PWR_OFS:  next_rdata = power_output_value;
      LV_OFS:   next_rdata = {1'b0, loop_voltage_sign,
                              loop_voltage_magnitude};
      LC_OFS:   next_rdata = {1'b0, loop_current_direction,
                              loop_current_magnitude};
      TIP_OFS:  next_rdata = tip_ground_voltage;
      RING_OFS: next_rdata = ring_ground_voltage;
      default:  next_rdata = 8'h00;
    endcase
  end

  // read data stand for the one cycle after the strobe only
  // zero outside the slot keeps a bus that ors many slaves clean
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= next_rdata;
    else
      RDATA <= 8'h00;
  end

  // status outputs for neighbouring logic
  // the tick output marks the cycle before the new values show
  assign SELECTOR    = power_monitor_selector;
  assign UPDATE_TICK = (state == LMR_PUBLISH);

endmodule // lmr_line_monitor

// ---- dv/lmr_line_monitor_assertions.sv ----
// checker for the register port of the line monitor readback block
`timescale 1ns/1ns
module lmr_line_monitor_chk
  import lmr_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYC
)
(
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic [2:0]        SELECTOR,
  input wire logic              UPDATE_TICK
);
  int         phase;
  logic [2:0] wsel;

  // selector bits of the write data, so $past sees a plain signal
  assign wsel = WDATA[SEL_MSB:0];

  // mirror of the publish divider; the load cycle falls one slot after
  // the divider wraps, since snapshot and convert take one cycle each
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      phase <= 0;
    else if (phase == UPDATE_CYCLES - 1)
      phase <= 0;
    else
      phase <= phase + 1;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  property p_rd_idle;
    RDATA != 8'h00 |-> $past(RD);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");

  property p_sel_wr;
    WR && ADDR == SEL_OFS |=> SELECTOR == $past(wsel);
  endproperty
  a_sel_wr: assert property (p_sel_wr)
    else $error("selector write lost");

  property p_sel_hold;
    !(WR && ADDR == SEL_OFS) |=> $stable(SELECTOR);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("selector moved without a write");

  property p_sel_rd;
    RD && ADDR == SEL_OFS |=> RDATA == {5'h00, SELECTOR};
  endproperty
  a_sel_rd: assert property (p_sel_rd)
    else $error("selector readback wrong");

  property p_tick_slot;
    UPDATE_TICK |-> phase == 1 % UPDATE_CYCLES;
  endproperty
  a_tick_slot: assert property (p_tick_slot)
    else $error("publish off its period");

  property p_tick_gap;
    UPDATE_TICK |=> !UPDATE_TICK [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("publish ticks too close");

  property p_mon_b7;
    RD && (ADDR == LV_OFS || ADDR == LC_OFS) |=> !RDATA[7];
  endproperty
  a_mon_b7: assert property (p_mon_b7)
    else $error("reserved bit set");

  property p_unmapped;
    RD && (ADDR < SEL_OFS || ADDR > RING_OFS) |=> RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // a read must not disturb the value a following read returns
  property p_rd_stable;
    RD && ADDR == TIP_OFS && !UPDATE_TICK ##1 RD && ADDR == TIP_OFS
      |=> RDATA == $past(RDATA);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("back to back reads differ");

  c_tick: cover property (UPDATE_TICK);
  c_sel_wr: cover property (WR && ADDR == SEL_OFS);
  c_unmapped: cover property (RD && ADDR > RING_OFS);
endmodule // lmr_line_monitor_chk

bind lmr_line_monitor lmr_line_monitor_chk
  #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (.CLK, .RST_N, .ADDR, .WDATA,
  .WR, .RD, .RDATA, .SELECTOR, .UPDATE_TICK);

// ---- dv/lmr_line_monitor_bench.sv ----
// self-checking bench for the line monitor readback registers
`timescale 1ns/1ns
module lmr_line_monitor_bench
  import lmr_pkg::*;
();
  localparam int NCYC = 4;  // short publish period keeps the run small

  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [7:0]                 addr = 8'h00;
  logic [7:0]                 wdata = 8'h00;
  logic                       wr = 1'b0;
  logic                       rd = 1'b0;
  logic [7:0]                 rdata;
  logic                       meas_valid = 1'b0;
  logic [7:0]                 tip = 8'h00;
  logic [7:0]                 ring = 8'h00;
  logic signed [LC_RAW_W-1:0] lc = '0;
  logic [PWR_W-1:0]           pw [8] = '{default: '0};
  logic [2:0]                 sel;
  logic                       update_tick;
  logic                       rd_pend = 1'b0;
  logic [7:0]                 exp_q [$];
  int                         n_mismatch = 0;
  int                         n_tests = 0;
  int                         seed = 20189;

  lmr_line_monitor #(.UPDATE_CYCLES(NCYC)) uut (
    .CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .MEAS_VALID(meas_valid), .TIP_CODE(tip),
    .RING_CODE(ring), .LOOP_CURRENT(lc), .Q1_POWER(pw[0]),
    .Q2_POWER(pw[1]), .Q3_POWER(pw[2]), .Q4_POWER(pw[3]),
    .Q5_POWER(pw[4]), .Q6_POWER(pw[5]), .SELECTOR(),
    .UPDATE_TICK(update_tick));

  // 20 MHz clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic compare(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // one bus cycle; for a read d is the value expected back
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
  endtask

  // pulse one sample and wait, bounded, for the publish that carries it
  task automatic publish();
    int k;
    k = 0;
    wr <= 1'b0;
    rd <= 1'b0;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (update_tick !== 1'b1 && k < 4 * NCYC);
    if (update_tick !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask

  function automatic logic [7:0] exp_pwr(input logic [2:0] s,
                                         input logic [PWR_W-1:0] p);
    longint v;
    v = (longint'(p) * ((s == SEL_Q3 || s == SEL_Q4) ? PWR_LO_RECIP
                                                      : PWR_HI_RECIP))
        >> RECIP_SHIFT;
    if (s > SEL_Q6)
      v = 0;
    return (v > 255) ? CODE_MAX : v[7:0];
  endfunction

  // polarity bit plus saturating magnitude; m is counts scale in 1/1024
  function automatic logic [7:0] exp_sm(input int d, input int m);
    int a;
    a = (d < 0) ? -d : d;
    a = (a * m) >> MAG_SHIFT;
    return {1'b0, d < 0, (a > 63) ? MAG_MAX : a[5:0]};
  endfunction

  // read data stands one cycle after the strobe: compare it there
  always @(posedge clk)
  begin
    if (rd_pend)
      compare(exp_q.pop_front(), rdata);
    rd_pend <= rd;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset contents, then one unmapped address
    for (int a = 'h4C; a <= 'h52; a++)
      bus(1'b0, 8'(a), MON_RST);
    // writes to the monitor group must leave it untouched
    for (int a = 'h4D; a <= 'h51; a++)
      bus(1'b1, 8'(a), 8'hFF);
    for (int a = 'h4D; a <= 'h51; a++)
      bus(1'b0, 8'(a), MON_RST);
    // every selector code; first two passes hit full scale both ways
    for (int i = 0; i < 24; i++)
    begin
      sel = 3'(i);
      tip <= (i < 2) ? {8{i[0]}} : 8'($random(seed));
      ring <= (i < 2) ? {8{~i[0]}} : 8'($random(seed));
      lc <= (i < 2) ? {~i[0], {9{i[0]}}} : 10'($random(seed));
      for (int q = 0; q < NUM_Q; q++)
        pw[q] <= (i < 2) ? '1 : 23'($random(seed)) >> i[3:1];
      bus(1'b1, SEL_OFS, {5'($random(seed)), sel});
      publish();
      bus(1'b0, SEL_OFS, {5'h00, sel});
      bus(1'b0, PWR_OFS, exp_pwr(sel, pw[sel]));
      bus(1'b0, LV_OFS,
          exp_sm(int'(ring) - int'(tip), LV_MULT));
      bus(1'b0, LC_OFS, exp_sm(int'(lc), LC_MULT));
      bus(1'b0, TIP_OFS, tip);
      bus(1'b0, TIP_OFS, tip);
      bus(1'b0, RING_OFS, ring);
    end
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule // lmr_line_monitor_bench
